// ### hw/mpta_pkg.sv
`default_nettype none
package mpta_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [11:0] OFS_WAKE_CTRL = 12'h0b8;
   localparam logic [11:0] OFS_TX_EVENT_SECONDS_HIGH_CAPTURE = 12'h0e8;
   localparam logic [11:0] OFS_PRECISION_TIMER_ADJUST = 12'h1d8;
   localparam logic [11:0] OFS_INT_STATUS = 12'h100;
   localparam logic [11:0] OFS_INT_MASK = 12'h104;
   localparam logic [11:0] OFS_TIMER_SEC_LO = 12'h110;
   localparam logic [11:0] OFS_TIMER_NS = 12'h114;
   localparam logic [11:0] OFS_TIMER_SEC_HI = 12'h118;
   // Field positions
   localparam int ARP_EN_BIT = 17;
   localparam int ADJUST_DIRECTION_BIT = 31;
   localparam int ADJUST_AMOUNT_MSB = 29;
   localparam int IRQ_TX_CAPTURE_BIT = 0;
   localparam int IRQ_ARP_WAKE_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int SEC_W = 48;
   localparam int SEC_HI_W = 16;
   localparam int NS_W = 30;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timer
   localparam int unsigned NS_PER_SEC_INT = 1000000000;
   localparam int unsigned CLK_FREQ_HZ = 125000000;
   localparam logic [NS_W-1:0] NS_PER_SEC = NS_W'(NS_PER_SEC_INT);
   localparam logic [NS_W-1:0] NS_PER_CLK = NS_W'(NS_PER_SEC_INT / CLK_FREQ_HZ);
endpackage : mpta_pkg
`default_nettype wire

// ### hw/mpta_timer_adj.sv
`timescale 1ns/1ps
`default_nettype none
module mpta_timer_adj #(
   parameter int SEC_W = mpta_pkg::SEC_W,
   parameter int NS_W = mpta_pkg::NS_W
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic adj_valid_in,
   input wire logic adj_dir_in,
   input wire logic [NS_W-1:0] adj_ns_in,
   output logic [SEC_W-1:0] sec_out,
   output logic [NS_W-1:0] ns_out
);
   logic [SEC_W-1:0] sec_r, sec_nxt;
   logic [NS_W-1:0] ns_r, ns_nxt;
   logic [NS_W-1:0] amt;
   logic [NS_W:0] sum;
   logic carry_whole, carry_part;

   always_comb begin
      amt = adj_ns_in;
      carry_whole = 1'b0;
      carry_part = 1'b0;
      sum = {1'b0, ns_r} + {1'b0, mpta_pkg::NS_PER_CLK};
      sec_nxt = sec_r;
      ns_nxt = ns_r;
      if (adj_valid_in) begin
         // Amount may exceed one second; fold the whole second first
         if (adj_ns_in >= mpta_pkg::NS_PER_SEC) begin
            amt = adj_ns_in - mpta_pkg::NS_PER_SEC;
            carry_whole = 1'b1;
         end
         if (!adj_dir_in) begin
            sum = {1'b0, ns_r} + {1'b0, amt}; // R5
            if (sum >= {1'b0, mpta_pkg::NS_PER_SEC}) begin
               sum = sum - {1'b0, mpta_pkg::NS_PER_SEC}; // R7
               carry_part = 1'b1;
            end
            ns_nxt = sum[NS_W-1:0];
            sec_nxt = sec_r + SEC_W'(carry_whole) + SEC_W'(carry_part); // R6
         end else begin
            if (amt > ns_r) begin
               ns_nxt = ns_r + (mpta_pkg::NS_PER_SEC - amt); // R7
               carry_part = 1'b1;
            end else begin
               ns_nxt = ns_r - amt; // R5
            end
            sec_nxt = sec_r - SEC_W'(carry_whole) - SEC_W'(carry_part); // R6
         end
      end else begin
         if (sum >= {1'b0, mpta_pkg::NS_PER_SEC}) begin
            ns_nxt = NS_W'(sum - {1'b0, mpta_pkg::NS_PER_SEC});
            sec_nxt = sec_r + SEC_W'(1'b1);
         end else begin
            ns_nxt = sum[NS_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sec_r <= '0;
         ns_r <= '0;
      end else begin
         sec_r <= sec_nxt;
         ns_r <= ns_nxt;
      end
   end

   assign sec_out = sec_r;
   assign ns_out = ns_r;

   AST_NS_IN_RANGE: assert property (@(posedge clock_in) disable iff (!nrst_in) // R7
      ns_r < mpta_pkg::NS_PER_SEC)
      else $error("nanoseconds left the one-second range");
   AST_ADD_APPLIED: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
      adj_valid_in && !adj_dir_in && ({1'b0, ns_r} + {1'b0, adj_ns_in}) < {1'b0,
      mpta_pkg::NS_PER_SEC} |=> ns_r == $past(ns_r) + $past(adj_ns_in) && sec_r == $past(sec_r))
      else $error("add adjustment not applied exactly");
   AST_ADD_CARRY: assert property (@(posedge clock_in) disable iff (!nrst_in) // R6
      adj_valid_in && !adj_dir_in && adj_ns_in < mpta_pkg::NS_PER_SEC &&
      ({1'b0, ns_r} + {1'b0, adj_ns_in}) >= {1'b0, mpta_pkg::NS_PER_SEC}
      |=> sec_r == $past(sec_r) + SEC_W'(1'b1))
      else $error("carry into seconds missing");
   AST_SUB_BORROW: assert property (@(posedge clock_in) disable iff (!nrst_in) // R6
      adj_valid_in && adj_dir_in && adj_ns_in < mpta_pkg::NS_PER_SEC && adj_ns_in > ns_r
      |=> sec_r == $past(sec_r) - SEC_W'(1'b1) &&
      ns_r == $past(ns_r) + (mpta_pkg::NS_PER_SEC - $past(adj_ns_in)))
      else $error("borrow from seconds wrong");
endmodule : mpta_timer_adj
`default_nettype wire

// ### hw/mpta_top.sv
// Overview of operation
// (R1) ARP wake event only while enable set
// (R2) Transmit event SFD captures upper timer seconds
// (R3) Every capture sets its status bit; irq_out rises only while unmasked
// (R4) Adjust bit 31 selects subtract or add
// (R5) Adjust amount is nanoseconds, applied once
// (R6) Nanosecond overflow or underflow carries seconds
// (R7) Nanoseconds wrap at one billion
`timescale 1ns/1ps
`default_nettype none
module mpta_top (
   input wire logic clock_in,
   input wire logic nrst_in,
   // AXI4-Lite slave
   input wire logic [mpta_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [mpta_pkg::DATA_W-1:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [mpta_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [mpta_pkg::DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // MAC side strobes on this clock
   input wire logic tx_event_sfd_in,
   input wire logic arp_request_in,
   output logic wake_event_out,
   output logic [mpta_pkg::SEC_W-1:0] timer_sec_out,
   output logic [mpta_pkg::NS_W-1:0] timer_ns_out,
   output logic irq_out
);
   localparam int SEC_W = mpta_pkg::SEC_W;
   localparam int NS_W = mpta_pkg::NS_W;
   localparam int SEC_HI_W = mpta_pkg::SEC_HI_W;
   localparam int IRQ_W = mpta_pkg::IRQ_W;

   // Bus state
   logic aw_hold_r, aw_hold_nxt;
   logic w_hold_r, w_hold_nxt;
   logic [mpta_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   // Block state
   logic arp_en_r, arp_en_nxt;
   logic [SEC_HI_W-1:0] captured_seconds_high_r, captured_seconds_high_nxt;
   logic [IRQ_W-1:0] int_status_r, int_status_nxt;
   logic [IRQ_W-1:0] int_mask_r, int_mask_nxt;
   logic irq_r, irq_nxt;
   logic wake_r, wake_nxt;
   logic adj_valid_r, adj_valid_nxt;
   logic adjust_direction_r, adjust_direction_nxt;
   logic [NS_W-1:0] adjust_amount_ns_r, adjust_amount_ns_nxt;
   logic [SEC_W-1:0] sec_r, sec_nxt;
   logic [NS_W-1:0] ns_r, ns_nxt;

   logic [SEC_W-1:0] timer_sec;
   logic [NS_W-1:0] timer_ns;
   logic aw_take, w_take, ar_take, wr_fire;
   logic [31:0] wmask, wval;
   logic [IRQ_W-1:0] irq_set, irq_clr;

   mpta_timer_adj #(
      .SEC_W(SEC_W),
      .NS_W(NS_W)
   ) u_timer (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .adj_valid_in(adj_valid_r),
      .adj_dir_in(adjust_direction_r),
      .adj_ns_in(adjust_amount_ns_r),
      .sec_out(timer_sec),
      .ns_out(timer_ns)
   );

   // Write channel: address and data accepted in either order
   always_comb begin
      aw_take = s_axi_awvalid_in & awready_r;
      w_take = s_axi_wvalid_in & wready_r;
      wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
      aw_hold_nxt = aw_hold_r | aw_take;
      w_hold_nxt = w_hold_r | w_take;
      waddr_nxt = aw_take ? s_axi_awaddr_in : waddr_r;
      wdata_nxt = w_take ? s_axi_wdata_in : wdata_r;
      wstrb_nxt = w_take ? s_axi_wstrb_in : wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (bvalid_r && s_axi_bready_in) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         if (waddr_r == mpta_pkg::OFS_WAKE_CTRL) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else if (waddr_r == mpta_pkg::OFS_PRECISION_TIMER_ADJUST) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else if (waddr_r == mpta_pkg::OFS_INT_STATUS) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else if (waddr_r == mpta_pkg::OFS_INT_MASK) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else if (waddr_r == mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else if (waddr_r == mpta_pkg::OFS_TIMER_SEC_LO ||
                      waddr_r == mpta_pkg::OFS_TIMER_NS ||
                      waddr_r == mpta_pkg::OFS_TIMER_SEC_HI) begin
            bresp_nxt = mpta_pkg::RESP_OKAY;
         end else begin
            bresp_nxt = mpta_pkg::RESP_SLVERR;
         end
      end
      awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
      wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
   end

   // Read channel: one cycle from address to data
   always_comb begin
      ar_take = s_axi_arvalid_in & arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready_in) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = mpta_pkg::RESP_OKAY;
         rdata_nxt = mpta_pkg::RESET_WORD;
         if (s_axi_araddr_in == mpta_pkg::OFS_WAKE_CTRL) begin
            rdata_nxt[mpta_pkg::ARP_EN_BIT] = arp_en_r;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE) begin
            rdata_nxt[SEC_HI_W-1:0] = captured_seconds_high_r;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_PRECISION_TIMER_ADJUST) begin
            // Write-only: reads as zero
            rdata_nxt = mpta_pkg::RESET_WORD;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_INT_STATUS) begin
            rdata_nxt[IRQ_W-1:0] = int_status_r;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_INT_MASK) begin
            rdata_nxt[IRQ_W-1:0] = int_mask_r;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_TIMER_SEC_LO) begin
            rdata_nxt = timer_sec[31:0];
         end else if (s_axi_araddr_in == mpta_pkg::OFS_TIMER_NS) begin
            rdata_nxt[NS_W-1:0] = timer_ns;
         end else if (s_axi_araddr_in == mpta_pkg::OFS_TIMER_SEC_HI) begin
            rdata_nxt[SEC_W-33:0] = timer_sec[SEC_W-1:32];
         end else begin
            rresp_nxt = mpta_pkg::RESP_SLVERR;
         end
      end
      arready_nxt = ~rvalid_nxt;
   end

   // Register effects, capture, wake and interrupts
   always_comb begin
      wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
      wval = wdata_r & wmask;
      arp_en_nxt = arp_en_r;
      int_mask_nxt = int_mask_r;
      irq_clr = '0;
      adj_valid_nxt = 1'b0;
      adjust_direction_nxt = adjust_direction_r;
      adjust_amount_ns_nxt = adjust_amount_ns_r;
      if (wr_fire) begin
         if (waddr_r == mpta_pkg::OFS_WAKE_CTRL) begin
            if (wmask[mpta_pkg::ARP_EN_BIT]) begin
               arp_en_nxt = wdata_r[mpta_pkg::ARP_EN_BIT];
            end
         end else if (waddr_r == mpta_pkg::OFS_INT_MASK) begin
            int_mask_nxt = (int_mask_r & ~wmask[IRQ_W-1:0]) | wval[IRQ_W-1:0];
         end else if (waddr_r == mpta_pkg::OFS_INT_STATUS) begin
            irq_clr = wval[IRQ_W-1:0];
         end else if (waddr_r == mpta_pkg::OFS_PRECISION_TIMER_ADJUST) begin
            adj_valid_nxt = 1'b1;
            adjust_direction_nxt = wval[mpta_pkg::ADJUST_DIRECTION_BIT]; // R4
            adjust_amount_ns_nxt = wval[mpta_pkg::ADJUST_AMOUNT_MSB:0]; // R5
         end
      end
      wake_nxt = arp_request_in & arp_en_r; // R1
      captured_seconds_high_nxt = captured_seconds_high_r;
      if (tx_event_sfd_in) begin
         captured_seconds_high_nxt = timer_sec[SEC_HI_W+31:32]; // R2
      end
      irq_set = '0;
      irq_set[mpta_pkg::IRQ_TX_CAPTURE_BIT] = tx_event_sfd_in; // R3
      irq_set[mpta_pkg::IRQ_ARP_WAKE_BIT] = wake_nxt;
      // Set wins over a simultaneous write-one clear
      int_status_nxt = (int_status_r & ~irq_clr) | irq_set;
      irq_nxt = |(int_status_nxt & int_mask_nxt); // R3
      sec_nxt = timer_sec;
      ns_nxt = timer_ns;
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= mpta_pkg::RESET_WORD;
         wstrb_r <= '0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= mpta_pkg::RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= mpta_pkg::RESET_WORD;
         rresp_r <= mpta_pkg::RESP_OKAY;
         arp_en_r <= 1'b0;
         captured_seconds_high_r <= '0;
         int_status_r <= '0;
         int_mask_r <= '0;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
         adj_valid_r <= 1'b0;
         adjust_direction_r <= 1'b0;
         adjust_amount_ns_r <= '0;
         sec_r <= '0;
         ns_r <= '0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         arp_en_r <= arp_en_nxt;
         captured_seconds_high_r <= captured_seconds_high_nxt;
         int_status_r <= int_status_nxt;
         int_mask_r <= int_mask_nxt;
         irq_r <= irq_nxt;
         wake_r <= wake_nxt;
         adj_valid_r <= adj_valid_nxt;
         adjust_direction_r <= adjust_direction_nxt;
         adjust_amount_ns_r <= adjust_amount_ns_nxt;
         sec_r <= sec_nxt;
         ns_r <= ns_nxt;
      end
   end

   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out = wready_r;
   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out = rdata_r;
   assign s_axi_rresp_out = rresp_r;
   assign wake_event_out = wake_r;
   assign irq_out = irq_r;
   // Registered copy of the timer, one cycle behind the counter
   assign timer_sec_out = sec_r;
   assign timer_ns_out = ns_r;

   sequence ta_write_fire;
      wr_fire && waddr_r == mpta_pkg::OFS_PRECISION_TIMER_ADJUST;
   endsequence

   sequence capture_unmasked;
      tx_event_sfd_in && int_mask_nxt[mpta_pkg::IRQ_TX_CAPTURE_BIT];
   endsequence

   AST_ARP_DISABLED: assert property (@(posedge clock_in) disable iff (!nrst_in) // R1
      arp_request_in && !arp_en_r |=> !wake_event_out)
      else $error("ARP request woke while disabled");
   AST_ARP_ENABLED: assert property (@(posedge clock_in) disable iff (!nrst_in) // R1
      arp_request_in && arp_en_r |=> wake_event_out)
      else $error("enabled ARP request did not wake");
   AST_CAPTURE_VALUE: assert property (@(posedge clock_in) disable iff (!nrst_in) // R2
      tx_event_sfd_in |=> captured_seconds_high_r == $past(timer_sec[SEC_HI_W+31:32]))
      else $error("capture holds wrong seconds");
   AST_CAPTURE_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in) // R2
      !tx_event_sfd_in |=> $stable(captured_seconds_high_r))
      else $error("capture changed without event");
   AST_CAPTURE_IRQ: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
      capture_unmasked |=> int_status_r[mpta_pkg::IRQ_TX_CAPTURE_BIT] && irq_out)
      else $error("capture raised no interrupt");
   AST_ADJ_DIRECTION: assert property (@(posedge clock_in) disable iff (!nrst_in) // R4
      ta_write_fire |=> adj_valid_r &&
      adjust_direction_r == $past(wval[mpta_pkg::ADJUST_DIRECTION_BIT]))
      else $error("adjust direction not taken from bit 31");
   AST_ADJ_ONCE: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
      ta_write_fire ##1 adj_valid_r |=> !adj_valid_r)
      else $error("adjustment applied more than once");

   sequence write_answered;
      bvalid_r && s_axi_bready_in;
   endsequence

   sequence read_answered;
      rvalid_r && s_axi_rready_in;
   endsequence

   AST_ADJ_AMOUNT: assert property (@(posedge clock_in) disable iff (!nrst_in) // R5
      ta_write_fire |=> adjust_amount_ns_r == $past(wval[mpta_pkg::ADJUST_AMOUNT_MSB:0]))
      else $error("adjust amount not taken from the written word");
   AST_CAPTURE_STATUS: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
      tx_event_sfd_in |=> int_status_r[mpta_pkg::IRQ_TX_CAPTURE_BIT])
      else $error("capture did not set its status bit");
   AST_WAKE_STATUS: assert property (@(posedge clock_in) disable iff (!nrst_in) // R1
      wake_event_out |-> int_status_r[mpta_pkg::IRQ_ARP_WAKE_BIT])
      else $error("wake event without its status bit");
   AST_WAKE_CAUSE: assert property (@(posedge clock_in) disable iff (!nrst_in) // R1
      wake_event_out |-> $past(arp_request_in) && $past(arp_en_r))
      else $error("wake event without an enabled request");
   AST_IRQ_LEVEL: assert property (@(posedge clock_in) disable iff (!nrst_in) // R3
      irq_out == (|(int_status_r & int_mask_r)))
      else $error("interrupt level disagrees with status and mask");
   AST_BRESP_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
      bvalid_r && !s_axi_bready_in |=> bvalid_r && $stable(bresp_r))
      else $error("write response dropped before bready");
   AST_RDATA_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
      rvalid_r && !s_axi_rready_in |=> rvalid_r && $stable(rdata_r) && $stable(rresp_r))
      else $error("read data dropped before rready");
   AST_WRITE_REOPEN: assert property (@(posedge clock_in) disable iff (!nrst_in)
      write_answered |=> !bvalid_r && awready_r && wready_r)
      else $error("write channels not reopened after response");
   AST_READ_REOPEN: assert property (@(posedge clock_in) disable iff (!nrst_in)
      read_answered |=> !rvalid_r && arready_r)
      else $error("read channel not reopened after response");
   AST_READ_ANSWER: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ar_take |=> rvalid_r)
      else $error("read data not offered one cycle after address");
endmodule : mpta_top
`default_nettype wire

// ### dv/mpta_mii_model.sv
`timescale 1ns/1ps
`default_nettype none
// MAC/MII-side strobes, one clock wide, launched after a rising edge
module mpta_mii_model (
   input wire logic clock_in,
   output logic tx_event_sfd_out,
   output logic arp_request_out
);
   initial begin
      tx_event_sfd_out = 1'b0;
      arp_request_out = 1'b0;
   end
   task automatic send_sfd();
      @(posedge clock_in);
      tx_event_sfd_out <= 1'b1;
      @(posedge clock_in);
      tx_event_sfd_out <= 1'b0;
   endtask : send_sfd
   task automatic send_arp();
      @(posedge clock_in);
      arp_request_out <= 1'b1;
      @(posedge clock_in);
      arp_request_out <= 1'b0;
   endtask : send_arp
endmodule : mpta_mii_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic awready, wready, bvalid, arready, rvalid, sfd, arp, wake, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [47:0] tsec;
   wire logic [29:0] tns;
   int mismatches = 0, n_compared = 0, cyc = 0, wake_cnt = 0;
   logic [31:0] d;
   logic [1:0] r;
   always #4 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end
   mpta_mii_model mpta_mii_model_i (.clock_in(clock_in), .tx_event_sfd_out(sfd),
      .arp_request_out(arp));
   mpta_top mpta_top_i (.clock_in(clock_in), .nrst_in(nrst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .tx_event_sfd_in(sfd),
      .arp_request_in(arp), .wake_event_out(wake), .timer_sec_out(tsec),
      .timer_ns_out(tns), .irq_out(irq));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge clock_in);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge clock_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock_in);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   // Expected timer worked out from elapsed ticks, one tick lost to the adjust
   task automatic adj(input logic dir, input longint amt, input logic b30);
      longint ns0, s0, c0, e;
      logic [1:0] resp;
      @(negedge clock_in);
      ns0 = tns;
      s0 = tsec;
      c0 = cyc;
      wr(mpta_pkg::OFS_PRECISION_TIMER_ADJUST, {dir, b30, amt[29:0]}, resp);
      repeat (4) @(posedge clock_in);
      @(negedge clock_in);
      e = ns0 + 8 * (cyc - c0 - 1) + (dir ? -amt : amt);
      if (e >= longint'(mpta_pkg::NS_PER_SEC_INT)) begin
         e -= mpta_pkg::NS_PER_SEC_INT;
         s0++;
      end else if (e < 0) begin
         e += mpta_pkg::NS_PER_SEC_INT;
         s0--;
      end
      chk(resp, mpta_pkg::RESP_OKAY);
      chk(tns, e);
      chk(tsec, s0[47:0]);
   endtask : adj
   initial begin
      repeat (50000) @(posedge clock_in);
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge clock_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rd(mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE, d, r);
      chk(d, 32'h0);
      rd(mpta_pkg::OFS_PRECISION_TIMER_ADJUST, d, r);
      chk({r, d}, {mpta_pkg::RESP_OKAY, 32'h0});
      rd(12'h0fc, d, r);
      chk(r, mpta_pkg::RESP_SLVERR);
      wr(12'h0fc, 32'hffff_ffff, r);
      chk(r, mpta_pkg::RESP_SLVERR);
      adj(1'b0, 40, 1'b0);
      adj(1'b1, 24, 1'b1);
      adj(1'b0, 999999900, 1'b0);
      adj(1'b1, 999999900, 1'b0);
      // Whole-second fold, seconds wrap below zero to all ones
      adj(1'b1, 1000000100, 1'b0);
      // Capture with interrupt masked, then unmasked, then cleared
      mpta_mii_model_i.send_sfd();
      repeat (2) @(negedge clock_in);
      chk(irq, 1'b0);
      rd(mpta_pkg::OFS_INT_STATUS, d, r);
      chk(d, 32'h1);
      wr(mpta_pkg::OFS_INT_MASK, 32'h3, r);
      repeat (2) @(negedge clock_in);
      chk(irq, 1'b1);
      wr(mpta_pkg::OFS_INT_STATUS, 32'h1, r);
      repeat (2) @(negedge clock_in);
      chk(irq, 1'b0);
      mpta_mii_model_i.send_sfd();
      @(negedge clock_in);
      chk(irq, 1'b1);
      rd(mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE, d, r);
      chk(d, 32'h0000_ffff);
      wr(mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE, 32'hffff_ffff, r);
      rd(mpta_pkg::OFS_TX_EVENT_SECONDS_HIGH_CAPTURE, d, r);
      chk({r, d}, {mpta_pkg::RESP_OKAY, 32'h0000_ffff});
      wr(mpta_pkg::OFS_INT_STATUS, 32'h1, r);
      // ARP request with the wake enable off, then on
      mpta_mii_model_i.send_arp();
      repeat (3) @(negedge clock_in);
      chk(wake_cnt, 0);
      rd(mpta_pkg::OFS_INT_STATUS, d, r);
      chk(d, 32'h0);
      wr(mpta_pkg::OFS_WAKE_CTRL, 32'h0002_0000, r);
      rd(mpta_pkg::OFS_WAKE_CTRL, d, r);
      chk(d, 32'h0002_0000);
      mpta_mii_model_i.send_arp();
      @(negedge clock_in);
      chk(wake, 1'b1);
      @(negedge clock_in);
      chk(wake, 1'b0);
      chk(irq, 1'b1);
      rd(mpta_pkg::OFS_INT_STATUS, d, r);
      chk(d, 32'h2);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
